// ---- src/atxm_params.svh ----
// What this block does
// R1 - With reset-control bit 1 set, each drive initialization sends a soft reset; with it clear, none is sent.
// R2 - Software keeps one reset method on and never pairs a clear soft-reset enable with a set skip bit.
// R3 - With reset-control bit 0 set, the reset pin pulses only at power-up or chip reset, else at every reset.
// R4 - UDMA is used with an ATA drive only when UDMA byte bit 7 is set and the drive supports an enabled mode.
// R5 - UDMA is used with an ATAPI drive only when UDMA byte bit 6 is set and the drive supports an enabled mode.
// R6 - UDMA byte bits 4, 3 and 2 enable UDMA modes 4, 3 and 2, the only UDMA modes supported.
// R7 - Software writes zero to UDMA byte bits 5, 1 and 0 and to bits 7 to 3 of the DMA/PIO byte.
// R8 - UDMA runs in the highest mode that is both enabled and supported by the drive.
// R9 - DMA/PIO byte bit 2 enables multiword DMA, used only if the drive supports it.
// R10 - DMA/PIO byte bit 1 enables PIO mode 4 and bit 0 enables PIO mode 3, both may be set.
// R11 - The PIO mode is the highest enabled and supported one among modes 0, 3 and 4.
// R12 - PIO mode 0 is always available as the fallback, with no enable bit.
// R13 - A usable UDMA mode is preferred over multiword DMA, which is preferred over PIO.
`ifndef ATXM_PARAMS_SVH
`define ATXM_PARAMS_SVH
// ----------------------------------------
// Configuration byte offsets
// ----------------------------------------
`define ATXM_RST_CTL_OFS 8'h05
`define ATXM_UDMA_CFG_OFS 8'h06
`define ATXM_DMA_PIO_CFG_OFS 8'h07
// ----------------------------------------
// Reset values
// ----------------------------------------
`define ATXM_RST_CTL_RST 8'h07
`define ATXM_UDMA_CFG_RST 8'hd4
`define ATXM_DMA_PIO_CFG_RST 8'h07
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ATXM_SKIP_PIN_BIT 0
`define ATXM_SRST_EN_BIT 1
`define ATXM_UDMA_ATA_BIT 7
`define ATXM_UDMA_ATAPI_BIT 6
`define ATXM_UDMA4_BIT 4
`define ATXM_UDMA3_BIT 3
`define ATXM_UDMA2_BIT 2
`define ATXM_MWDMA_BIT 2
`define ATXM_PIO4_BIT 1
`define ATXM_PIO3_BIT 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define ATXM_CLK_PERIOD_NS 25
`define ATXM_PIN_RESET_NS 25000
`define ATXM_PIN_RESET_CYC ((`ATXM_PIN_RESET_NS + `ATXM_CLK_PERIOD_NS - 1) / `ATXM_CLK_PERIOD_NS)
`endif

// ---- src/atxm_pkg.sv ----
package atxm_pkg;
	typedef enum logic [2:0] {
		XC_PIO = 3'b001,
		XC_MWDMA = 3'b010,
		XC_UDMA = 3'b100
	} atxm_class_t;
	typedef struct packed {
		atxm_class_t cls;
		logic [2:0] mode;
	} atxm_xfer_t;
	typedef struct packed {
		logic udma2;
		logic udma3;
		logic udma4;
		logic mwdma2;
		logic pio3;
		logic pio4;
	} atxm_support_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PIN = 4'b0010,
		ST_SRST = 4'b0100,
		ST_MODE = 4'b1000
	} atxm_state_t;
endpackage

// ---- src/atxm_mode_select.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "atxm_params.svh"
module atxm_mode_select import atxm_pkg::*; (
	// Configuration
	input wire logic [7:0] udma_cfg_in,
	input wire logic [7:0] dma_pio_cfg_in,
	// Drive report
	input wire logic atapi_in,
	input wire atxm_support_t sup_in,
	// Result
	output atxm_xfer_t xfer_out
);
	logic udma_ok;
	logic u4;
	logic u3;
	logic u2;
	logic mw;
	logic p4;
	logic p3;
	assign udma_ok = atapi_in ? udma_cfg_in[`ATXM_UDMA_ATAPI_BIT] : udma_cfg_in[`ATXM_UDMA_ATA_BIT]; // [R4] [R5]
	assign u4 = udma_cfg_in[`ATXM_UDMA4_BIT] & sup_in.udma4; // [R6]
	assign u3 = udma_cfg_in[`ATXM_UDMA3_BIT] & sup_in.udma3; // [R6]
	assign u2 = udma_cfg_in[`ATXM_UDMA2_BIT] & sup_in.udma2; // [R6]
	assign mw = dma_pio_cfg_in[`ATXM_MWDMA_BIT] & sup_in.mwdma2; // [R9]
	assign p4 = dma_pio_cfg_in[`ATXM_PIO4_BIT] & sup_in.pio4; // [R10]
	assign p3 = dma_pio_cfg_in[`ATXM_PIO3_BIT] & sup_in.pio3; // [R10]
	// Reserved bits are ignored so a stray one cannot pick an unsupported mode.
	always_comb
	begin
		xfer_out.cls = XC_PIO;
		xfer_out.mode = 3'h0; // [R12]
		if (udma_ok && (u4 || u3 || u2)) // [R13]
		begin
			xfer_out.cls = XC_UDMA;
			xfer_out.mode = u4 ? 3'h4 : (u3 ? 3'h3 : 3'h2); // [R8]
		end
		else if (mw) // [R13]
		begin
			xfer_out.cls = XC_MWDMA;
			xfer_out.mode = 3'h2;
		end
		else if (p4) // [R11]
			xfer_out.mode = 3'h4;
		else if (p3)
			xfer_out.mode = 3'h3;
	end
endmodule // atxm_mode_select
`default_nettype wire

// ---- src/atxm_config.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "atxm_params.svh"
module atxm_config import atxm_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Configuration byte port
	input wire logic cfg_wr_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic [7:0] cfg_wdata_in,
	output logic [7:0] cfg_rdata_out,
	// Drive report and initialization control
	input wire logic init_req_in,
	input wire logic atapi_in,
	input wire atxm_support_t sup_in,
	output logic init_busy_out,
	output logic init_done_out,
	// Drive reset
	output logic drive_hw_reset_pin_n_out,
	output logic srst_req_out,
	// Chosen transfer mode
	output atxm_xfer_t xfer_out
);
	// ----------------------------------------
	// Configuration bytes
	// ----------------------------------------
	logic [7:0] rst_ctl_reg;
	logic [7:0] udma_config_byte_reg;
	logic [7:0] dma_pio_config_byte_reg;
	atxm_state_t state_reg;
	atxm_state_t state_next;
	logic [9:0] pin_cnt_reg;
	logic pin_last;
	logic accept;
	atxm_xfer_t sel;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rst_ctl_reg <= `ATXM_RST_CTL_RST;
			udma_config_byte_reg <= `ATXM_UDMA_CFG_RST;
			dma_pio_config_byte_reg <= `ATXM_DMA_PIO_CFG_RST;
		end
		else if (cfg_wr_in)
		begin
			case (cfg_addr_in)
				`ATXM_RST_CTL_OFS: rst_ctl_reg <= cfg_wdata_in;
				`ATXM_UDMA_CFG_OFS: udma_config_byte_reg <= cfg_wdata_in;
				`ATXM_DMA_PIO_CFG_OFS: dma_pio_config_byte_reg <= cfg_wdata_in;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cfg_rdata_out <= 8'h00;
		else
		begin
			case (cfg_addr_in)
				`ATXM_RST_CTL_OFS: cfg_rdata_out <= rst_ctl_reg;
				`ATXM_UDMA_CFG_OFS: cfg_rdata_out <= udma_config_byte_reg;
				`ATXM_DMA_PIO_CFG_OFS: cfg_rdata_out <= dma_pio_config_byte_reg;
				default: cfg_rdata_out <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Drive initialization sequence
	// ----------------------------------------
	// Chip reset enters the pin phase directly, so power-up always pulses the pin.
	assign accept = (state_reg == ST_IDLE) && init_req_in;
	assign pin_last = (pin_cnt_reg == 10'(`ATXM_PIN_RESET_CYC - 1));

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (init_req_in)
				begin
					if (rst_ctl_reg[`ATXM_SKIP_PIN_BIT]) // [R3]
						state_next = rst_ctl_reg[`ATXM_SRST_EN_BIT] ? ST_SRST : ST_MODE; // [R1]
					else
						state_next = ST_PIN; // [R3]
				end
			end
			ST_PIN:
			begin
				if (pin_last)
					state_next = rst_ctl_reg[`ATXM_SRST_EN_BIT] ? ST_SRST : ST_MODE; // [R1]
			end
			ST_SRST: state_next = ST_MODE;
			ST_MODE: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_reg <= ST_PIN;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			pin_cnt_reg <= 10'h000;
		else if (state_reg == ST_PIN && !pin_last)
			pin_cnt_reg <= pin_cnt_reg + 10'h001;
		else
			pin_cnt_reg <= 10'h000;
	end

	// The pin is low through chip reset itself and through the timed phase.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			drive_hw_reset_pin_n_out <= 1'b0;
		else
			drive_hw_reset_pin_n_out <= (state_next != ST_PIN); // [R3]
	end

	assign srst_req_out = (state_reg == ST_SRST); // [R1]
	assign init_busy_out = (state_reg != ST_IDLE);

	// ----------------------------------------
	// Transfer mode choice
	// ----------------------------------------
	atxm_mode_select u_sel (
		.udma_cfg_in(udma_config_byte_reg),
		.dma_pio_cfg_in(dma_pio_config_byte_reg),
		.atapi_in(atapi_in),
		.sup_in(sup_in),
		.xfer_out(sel)
	);

	// The mode is frozen per initialization so it never changes mid-transfer.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			xfer_out <= '{cls: XC_PIO, mode: 3'h0};
			init_done_out <= 1'b0;
		end
		else
		begin
			init_done_out <= (state_reg == ST_MODE);
			if (state_reg == ST_MODE)
				xfer_out <= sel; // [R8] [R13]
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic udma_ok_h;
	logic udma_any_h;
	logic mw_h;
	logic st_mode_h;
	logic u4_h;
	logic u3_h;
	logic u2_h;
	logic p4_h;
	logic p3_h;
	logic pick_udma_h;
	logic pick_dma_h;
	logic pick_pio_h;
	logic [10:0] low_run_reg;
	// Low time is counted apart from the sequencer, so a slip in its counter shows here.
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			low_run_reg <= 11'h000;
		else if (!drive_hw_reset_pin_n_out)
			low_run_reg <= low_run_reg + 11'h001;
		else
			low_run_reg <= 11'h000;
	end
	assign udma_ok_h = atapi_in ? udma_config_byte_reg[`ATXM_UDMA_ATAPI_BIT] : udma_config_byte_reg[`ATXM_UDMA_ATA_BIT];
	assign u4_h = udma_config_byte_reg[`ATXM_UDMA4_BIT] && sup_in.udma4;
	assign u3_h = udma_config_byte_reg[`ATXM_UDMA3_BIT] && sup_in.udma3;
	assign u2_h = udma_config_byte_reg[`ATXM_UDMA2_BIT] && sup_in.udma2;
	assign p4_h = dma_pio_config_byte_reg[`ATXM_PIO4_BIT] && sup_in.pio4;
	assign p3_h = dma_pio_config_byte_reg[`ATXM_PIO3_BIT] && sup_in.pio3;
	assign udma_any_h = udma_ok_h && (u4_h || u3_h || u2_h);
	assign mw_h = dma_pio_config_byte_reg[`ATXM_MWDMA_BIT] && sup_in.mwdma2;
	assign st_mode_h = (state_reg == ST_MODE);
	assign pick_udma_h = st_mode_h && udma_ok_h;
	assign pick_dma_h = st_mode_h && !udma_any_h;
	assign pick_pio_h = pick_dma_h && !mw_h;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	skip_pin_a: assert property (accept && rst_ctl_reg[0] |=> drive_hw_reset_pin_n_out [*2]) // [R3]
		else $error("pin asserted although skip is set");
	pin_pulse_a: assert property (accept && !rst_ctl_reg[0] |=> !drive_hw_reset_pin_n_out [*8]) // [R3]
		else $error("pin not held low after init request");
	srst_issue_a: assert property (accept && rst_ctl_reg[1:0] == 2'b11 |=> srst_req_out) // [R1]
		else $error("soft reset not issued");
	srst_skip_a: assert property (srst_req_out |-> rst_ctl_reg[1] && drive_hw_reset_pin_n_out) // [R1]
		else $error("soft reset issued while disabled");
	udma_ata_a: assert property (st_mode_h && !atapi_in && !udma_config_byte_reg[7] |=> xfer_out.cls != XC_UDMA) // [R4]
		else $error("udma used with ata drive while disabled");
	udma_atapi_a: assert property (st_mode_h && atapi_in && !udma_config_byte_reg[6] |=> xfer_out.cls != XC_UDMA) // [R5]
		else $error("udma used with atapi drive while disabled");
	udma_top_a: assert property (pick_udma_h && u4_h |=> xfer_out == '{cls: XC_UDMA, mode: 3'h4}) // [R6] [R8]
		else $error("udma mode 4 not chosen");
	udma_mid_a: assert property (pick_udma_h && !u4_h && u3_h |=> xfer_out == '{cls: XC_UDMA, mode: 3'h3}) // [R6] [R8]
		else $error("udma mode 3 not chosen");
	udma_low_a: assert property (pick_udma_h && !u4_h && !u3_h && u2_h |=> xfer_out.mode == 3'h2) // [R6] [R8]
		else $error("udma mode 2 not chosen");
	mwdma_pick_a: assert property (pick_dma_h && mw_h |=> xfer_out == '{cls: XC_MWDMA, mode: 3'h2}) // [R9] [R13]
		else $error("multiword dma not chosen");
	pio_top_a: assert property (pick_pio_h && p4_h |=> xfer_out == '{cls: XC_PIO, mode: 3'h4}) // [R10] [R11]
		else $error("pio mode 4 not chosen");
	pio_mid_a: assert property (pick_pio_h && !p4_h && p3_h |=> xfer_out == '{cls: XC_PIO, mode: 3'h3}) // [R10] [R11]
		else $error("pio mode 3 not chosen");
	pio_zero_a: assert property (pick_pio_h && !p4_h && !p3_h |=> xfer_out == '{cls: XC_PIO, mode: 3'h0}) // [R12]
		else $error("pio mode 0 fallback missing");
	mode_hold_a: assert property (!st_mode_h |=> $stable(xfer_out)) // [R8]
		else $error("transfer mode changed outside the mode phase");
	pin_width_a: assert property ($rose(drive_hw_reset_pin_n_out) |-> low_run_reg == 11'(`ATXM_PIN_RESET_CYC)) // [R3]
		else $error("reset pin pulse has the wrong width");
	idle_pin_a: assert property (state_reg == ST_IDLE |-> drive_hw_reset_pin_n_out) // [R3]
		else $error("reset pin low while idle");
	srst_once_a: assert property (srst_req_out |=> !srst_req_out) // [R1]
		else $error("soft reset request longer than one cycle");

	pin_init_c: cover property (accept && !rst_ctl_reg[0] ##1 !drive_hw_reset_pin_n_out);
	srst_only_c: cover property (accept && rst_ctl_reg[1:0] == 2'b11 ##1 srst_req_out);
	udma_pick_c: cover property (init_done_out && xfer_out.cls == XC_UDMA);
	pio0_pick_c: cover property (init_done_out && xfer_out.cls == XC_PIO && xfer_out.mode == 3'h0);
	mwdma_pick_c: cover property (init_done_out && xfer_out.cls == XC_MWDMA);
endmodule // atxm_config
`default_nettype wire

// ---- dv/atxm_drive_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module atxm_drive_model import atxm_pkg::*; (
	// Clock and bench control
	input wire logic clk_in,
	input wire logic clr_in,
	input wire logic atapi_sel_in,
	input wire atxm_support_t sup_sel_in,
	// Bridge side
	input wire logic drive_hw_reset_pin_n_in,
	input wire logic srst_req_in,
	output logic atapi_out,
	output atxm_support_t sup_out,
	// Observations
	output logic [15:0] pin_low_cnt_out,
	output logic [7:0] srst_cnt_out
);
	// The drive reports its kind and modes as plain levels.
	assign atapi_out = atapi_sel_in;
	assign sup_out = sup_sel_in;
	always_ff @(posedge clk_in)
	begin
		if (clr_in)
			pin_low_cnt_out <= 16'h0000;
		else if (!drive_hw_reset_pin_n_in)
			pin_low_cnt_out <= pin_low_cnt_out + 16'h0001;
	end
	always_ff @(posedge clk_in)
	begin
		if (clr_in)
			srst_cnt_out <= 8'h00;
		else if (srst_req_in)
			srst_cnt_out <= srst_cnt_out + 8'h01;
	end
endmodule // atxm_drive_model
`default_nettype wire

// ---- dv/atxm_config_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module atxm_config_tb_top import atxm_pkg::*;;
	logic clk_in, rst_in, cfg_wr, init_req, atapi, atapi_sel, busy, done, pin_n, srst, clr;
	logic [7:0] addr, wdata, rdata, srst_cnt, rd;
	logic [15:0] pin_cnt;
	atxm_support_t sup, sup_sel;
	atxm_xfer_t xfer;
	int fails, num_checks;
	atxm_config DUT (.clk_in(clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr), .cfg_addr_in(addr),
		.cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .init_req_in(init_req), .atapi_in(atapi),
		.sup_in(sup), .init_busy_out(busy), .init_done_out(done), .drive_hw_reset_pin_n_out(pin_n),
		.srst_req_out(srst), .xfer_out(xfer));
	atxm_drive_model drv (.clk_in(clk_in), .clr_in(clr), .atapi_sel_in(atapi_sel), .sup_sel_in(sup_sel),
		.drive_hw_reset_pin_n_in(pin_n), .srst_req_in(srst), .atapi_out(atapi), .sup_out(sup),
		.pin_low_cnt_out(pin_cnt), .srst_cnt_out(srst_cnt));
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		cfg_wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_in);
		cfg_wr <= 1'b0;
	endtask
	task automatic rd_byte(input logic [7:0] a);
		@(posedge clk_in);
		addr <= a;
		repeat (2) @(posedge clk_in);
		#1 rd = rdata;
	endtask
	// Waits for the done pulse, then judges mode and reset activity.
	task automatic wait_done(input string nm, input atxm_class_t c, input logic [2:0] m, input logic [15:0] p,
		input logic [7:0] s);
		int i;
		for (i = 0; i < 1100 && done !== 1'b1; i++)
		begin
			@(posedge clk_in);
			#1;
		end
		chk("done", done, 1'b1);
		chk("idle", busy, 1'b0);
		chk("class", xfer.cls, c);
		chk("mode", xfer.mode, m);
		chk("pin low", pin_cnt, p);
		chk("srst", srst_cnt, s);
		$display("test %s done", nm);
	endtask
	// Only legal reset-control values and zero reserved bits are written.
	task automatic run_init(input string nm, input logic [7:0] rc, input logic [7:0] ud, input logic [7:0] dp,
		input logic at, input atxm_support_t sp, input atxm_class_t c, input logic [2:0] m, input logic [15:0] p,
		input logic [7:0] s);
		wr_byte(8'h05, rc);
		wr_byte(8'h06, ud);
		wr_byte(8'h07, dp);
		rd_byte(8'h06);
		chk("udma byte", rd, ud);
		@(posedge clk_in);
		atapi_sel <= at;
		sup_sel <= sp;
		clr <= 1'b1;
		@(posedge clk_in);
		clr <= 1'b0;
		init_req <= 1'b1;
		@(posedge clk_in);
		init_req <= 1'b0;
		#1;
		chk("busy", busy, 1'b1);
		wait_done(nm, c, m, p, s);
	endtask
	task automatic t_power_up;
		chk("busy", busy, 1'b1);
		wait_done("power", XC_UDMA, 3'h4, 16'h03e8, 8'h01);
	endtask
	task automatic t_regs;
		rd_byte(8'h05);
		chk("rst ctl", rd, 8'h07);
		rd_byte(8'h06);
		chk("udma rst", rd, 8'hd4);
		rd_byte(8'h07);
		chk("pio rst", rd, 8'h07);
		wr_byte(8'h10, 8'h5a);
		rd_byte(8'h10);
		chk("unmapped", rd, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_resets;
		run_init("soft", 8'h03, 8'h94, 8'h07, 1'b0, 6'h27, XC_UDMA, 3'h2, 16'h0000, 8'h01);
		run_init("both", 8'h02, 8'h4c, 8'h07, 1'b1, 6'h3f, XC_UDMA, 3'h3, 16'h03e8, 8'h01);
		run_init("pin", 8'h00, 8'h14, 8'h07, 1'b0, 6'h3f, XC_MWDMA, 3'h2, 16'h03e8, 8'h00);
	endtask
	task automatic t_classes;
		run_init("atapi", 8'h03, 8'h9c, 8'h07, 1'b1, 6'h3f, XC_MWDMA, 3'h2, 16'h0000, 8'h01);
		run_init("pio4", 8'h03, 8'hd4, 8'h03, 1'b0, 6'h07, XC_PIO, 3'h4, 16'h0000, 8'h01);
		run_init("pio0", 8'h03, 8'hd4, 8'h01, 1'b0, 6'h05, XC_PIO, 3'h0, 16'h0000, 8'h01);
		run_init("pio3", 8'h03, 8'hd4, 8'h03, 1'b0, 6'h02, XC_PIO, 3'h3, 16'h0000, 8'h01);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		rst_in = 1'b1;
		cfg_wr = 1'b0;
		init_req = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		atapi_sel = 1'b0;
		sup_sel = 6'h3f;
		clr = 1'b1;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		clr <= 1'b0;
		t_power_up();
		t_regs();
		t_resets();
		t_classes();
		tally_and_finish();
	end
	initial
	begin
		#(25 * 20000);
		fails++;
		tally_and_finish();
	end
endmodule // atxm_config_tb_top
`default_nettype wire
